// >>> kscan_pkg.sv
// keypad scanner register bank: shared constants and types
// assumes a 100 MHz single clock and a page/address register port
package kscan_pkg;

   // ==========================================================
   // register map (page, address)
   localparam logic       PAGE_DATA       = 1'b0;
   localparam logic       PAGE_CTRL       = 1'b1;
   localparam logic [5:0] ADDR_KEY_RESULT = 6'h04;  // page 0
   localparam logic [5:0] ADDR_DAC_LEVEL  = 6'h0b;  // page 0
   localparam logic [5:0] ADDR_ZERO       = 6'h10;  // page 0
   localparam logic [5:0] ADDR_CONV_LAST  = 6'h0a;  // page 0, conversion words 00-03, 05-0a
   localparam logic [5:0] ADDR_KEY_CTRL   = 6'h01;  // page 1
   localparam logic [5:0] ADDR_SOFT_RESET = 6'h04;  // page 1
   localparam logic [5:0] ADDR_KEY_MASK   = 6'h10;  // page 1

   // ==========================================================
   // field positions and fixed values
   localparam int          BIT_KEY_PRESSED = 15;
   localparam int          BIT_SCAN_STATE  = 14;
   localparam int          DEB_SEL_LSB     = 11;
   localparam logic [7:0]  SOFT_RESET_KEY  = 8'hbb;
   localparam logic [15:0] READ_RESERVED   = 16'hffff;
   localparam logic [15:0] READ_ZERO       = 16'h0000;
   localparam logic [15:0] MASK_RESET      = 16'h0000;
   localparam logic [15:0] RESULT_RESET    = 16'h0000;
   localparam logic [2:0]  DEB_SEL_RESET   = 3'h0;
   localparam logic [7:0]  DAC_RESET       = 8'h80;

   // ==========================================================
   // timing
   localparam int CLK_FREQ_MHZ = 100;
   localparam int MS_TIME_US   = 1000;
   localparam int MS_CYCLES    = MS_TIME_US * CLK_FREQ_MHZ;  // one debounce time unit
   localparam int ROW_CYCLES   = 8;                          // settle time per driven row
   localparam int CONV_WORDS   = 10;
   localparam int CONV_BITS    = 12;

   // debounce time in ms per select code
   function automatic logic [6:0] kscan_debounce_ms(input logic [2:0] sel);
      case (sel)
         3'h0:    kscan_debounce_ms = 7'd2;
         3'h1:    kscan_debounce_ms = 7'd10;
         3'h2:    kscan_debounce_ms = 7'd20;
         3'h3:    kscan_debounce_ms = 7'd50;
         3'h4:    kscan_debounce_ms = 7'd60;
         3'h5:    kscan_debounce_ms = 7'd80;
         3'h6:    kscan_debounce_ms = 7'd100;
         default: kscan_debounce_ms = 7'd120;
      endcase
   endfunction

   // scanner states, gray along idle -> debounce -> held -> stopped
   typedef enum logic [1:0] {
      ST_IDLE     = 2'b00,
      ST_DEBOUNCE = 2'b01,
      ST_HELD     = 2'b11,
      ST_STOPPED  = 2'b10
   } kscan_state_t;

endpackage

// >>> kscan_conv_store.sv
// conversion result store: right-justified words cleared by reset
// assumes writes come from the converter side, one word per cycle
`timescale 1ns/10ps
module kscan_conv_store
   import kscan_pkg::*;
#(
   parameter int WORDS = CONV_WORDS,
   parameter int BITS  = CONV_BITS
) (
   input  wire logic                     clock_in,    // system clock
   input  wire logic                     rstn_in,     // synchronised reset, active low
   input  wire logic                     clear_in,    // software reset request
   input  wire logic                     wr_en_in,    // store one result
   input  wire logic [$clog2(WORDS)-1:0] wr_idx_in,   // result slot
   input  wire logic [BITS-1:0]          wr_data_in,  // raw result, lsb first
   input  wire logic [$clog2(WORDS)-1:0] rd_idx_in,   // slot to read
   output logic      [15:0]              rd_q_out     // registered read word
);

   // ==========================================================
   // storage
   logic [BITS-1:0] word_q [WORDS];
   logic [15:0]     next_rd_q;

   // one register per word, so a software reset clears them all at once
   generate
      for (genvar i = 0; i < WORDS; i++) begin : g_word
         logic [BITS-1:0] next_word;
         always_comb begin
            next_word = word_q[i];
            if (clear_in) begin
               next_word = '0;
            end else if (wr_en_in && (wr_idx_in == ($clog2(WORDS))'(i))) begin
               next_word = wr_data_in;
            end
         end
         always_ff @(posedge clock_in or negedge rstn_in) begin
            if (!rstn_in) begin
               word_q[i] <= '0;
            end else begin
               word_q[i] <= next_word;
            end
         end
      end
   endgenerate

   // ==========================================================
   // read port: upper bits above the result read as zero
   always_comb begin
      next_rd_q = 16'h0000;
      if (int'(rd_idx_in) < WORDS) begin
         next_rd_q[BITS-1:0] = word_q[rd_idx_in];
      end
   end

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rd_q_out <= 16'h0000;
      end else begin
         rd_q_out <= next_rd_q;
      end
   end

endmodule

// >>> kscan_regs.sv
// keypad matrix scanner with its register bank and conversion store
// assumes a host register port (page, address, strobes) and a 4x4 matrix
`timescale 1ns/10ps
module kscan_regs
   import kscan_pkg::*;
#(
   parameter int MS_TICK_CYCLES = MS_CYCLES   // cycles per ms, shorten in simulation
) (
   input  wire logic        clock_in,        // 100 MHz clock
   input  wire logic        rstn_in,         // asynchronous reset, active low
   input  wire logic        rd_en_in,        // register read request
   input  wire logic        wr_en_in,        // register write request
   input  wire logic        page_in,         // register page
   input  wire logic [5:0]  addr_in,         // register address
   input  wire logic [15:0] wr_data_in,      // write data
   input  wire logic [3:0]  col_sense_in,    // column senses, high = key closed
   input  wire logic        conv_wr_in,      // conversion result strobe
   input  wire logic [3:0]  conv_idx_in,     // conversion result slot
   input  wire logic [11:0] conv_data_in,    // conversion result
   output logic      [15:0] rd_data_out,     // read data, two cycles after request
   output logic             rd_valid_out,    // read data valid pulse
   output logic      [3:0]  row_drive_out,   // one-hot row drive
   output logic             key_irq_n_out,   // keypad interrupt, active low
   output logic      [7:0]  dac_level_out    // dac output register
);

   localparam int DIV_W = $clog2(MS_TICK_CYCLES + 1);

   // ==========================================================
   // reset release through two flops
   logic rst_meta;
   logic rst_n;
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // ==========================================================
   // decode
   function automatic logic is_reg(input logic pg, input logic [5:0] ad,
                                   input logic want_pg, input logic [5:0] want_ad);
      is_reg = (pg == want_pg) && (ad == want_ad);
   endfunction

   // conversion slot for page-0 address, or no hit
   function automatic logic [4:0] conv_slot(input logic pg, input logic [5:0] ad);
      if (pg != PAGE_DATA) begin
         conv_slot = 5'h00;
      end else if (ad < ADDR_KEY_RESULT) begin
         conv_slot = {1'b1, ad[3:0]};
      end else if ((ad > ADDR_KEY_RESULT) && (ad <= ADDR_CONV_LAST)) begin
         conv_slot = {1'b1, 4'(ad - 6'h01)};
      end else begin
         conv_slot = 5'h00;
      end
   endfunction

   logic       wr_ctrl;
   logic       wr_mask;
   logic       wr_dac;
   logic       soft_hit;
   logic [4:0] rd_slot;
   assign wr_ctrl  = wr_en_in && is_reg(page_in, addr_in, PAGE_CTRL, ADDR_KEY_CTRL);
   assign wr_mask  = wr_en_in && is_reg(page_in, addr_in, PAGE_CTRL, ADDR_KEY_MASK);
   assign wr_dac   = wr_en_in && is_reg(page_in, addr_in, PAGE_DATA, ADDR_DAC_LEVEL);
   // only the exact key byte resets; any other value is dropped
   assign soft_hit = wr_en_in && is_reg(page_in, addr_in, PAGE_CTRL, ADDR_SOFT_RESET)
                     && (wr_data_in[15:8] == SOFT_RESET_KEY);
   assign rd_slot  = conv_slot(page_in, addr_in);

   // ==========================================================
   // state
   kscan_state_t     state, next_state;
   logic [2:0]       debounce_select, next_debounce_select;
   logic [15:0]      key_mask, next_key_mask;
   logic [15:0]      key_scan_result, next_key_scan_result;
   logic             key_pressed_flag, next_key_pressed_flag;
   logic [7:0]       next_dac_level;
   logic [DIV_W-1:0] ms_div, next_ms_div;
   logic [6:0]       ms_count, next_ms_count;
   logic [2:0]       row_cnt, next_row_cnt;
   logic [1:0]       row_sel, next_row_sel;
   logic [15:0]      raw_acc, next_raw_acc;
   logic [3:0]       next_row_drive;
   logic             scanning;
   logic             row_step;
   logic             pass_done;
   logic             ms_tick;
   logic             db_done;
   logic [15:0]      frame;
   logic             scan_ready;

   assign scanning   = (state != ST_STOPPED);
   assign ms_tick    = (ms_div == DIV_W'(MS_TICK_CYCLES - 1));
   assign row_step   = scanning && (row_cnt == 3'(ROW_CYCLES - 1));
   assign pass_done  = row_step && (row_sel == 2'h3);
   assign db_done    = (ms_count >= kscan_debounce_ms(debounce_select));
   assign scan_ready = (state != ST_DEBOUNCE);
   // masked keys are dropped before anything looks at the frame
   assign frame      = next_raw_acc & ~key_mask;

   // row sequencing: each row is held ROW_CYCLES, columns sampled at its end
   always_comb begin
      next_row_cnt   = row_cnt;
      next_row_sel   = row_sel;
      next_raw_acc   = raw_acc;
      next_row_drive = 4'h0;
      if (scanning) begin
         next_row_cnt = row_step ? 3'h0 : 3'(row_cnt + 3'h1);
         if (row_step) begin
            // the matrix itself ghosts; a closed loop reads as a key
            next_raw_acc[{row_sel, 2'b00} +: 4] = col_sense_in;
            next_row_sel = 2'(row_sel + 2'h1);
         end
         next_row_drive = 4'h1 << next_row_sel;
      end else begin
         next_row_cnt = 3'h0;
         next_row_sel = 2'h0;
      end
      if (soft_hit) begin
         next_row_cnt = 3'h0;
         next_row_sel = 2'h0;
         next_raw_acc = 16'h0000;
      end
   end

   // debounce clock: ms divider free running, counting only while debouncing
   always_comb begin
      next_ms_div   = ms_tick ? '0 : DIV_W'(ms_div + 1'b1);
      next_ms_count = ms_count;
      if (state != ST_DEBOUNCE) begin
         next_ms_count = 7'h00;
      end else if (ms_tick && !db_done) begin
         next_ms_count = 7'(ms_count + 7'h01);
      end
   end

   // scanner state and the registers software sees
   always_comb begin
      next_state            = state;
      next_debounce_select  = debounce_select;
      next_key_mask         = key_mask;
      next_key_scan_result  = key_scan_result;
      next_key_pressed_flag = key_pressed_flag;
      next_dac_level        = dac_level_out;
      case (state)
         ST_IDLE: begin
            if (pass_done && (frame != 16'h0000)) begin
               next_state = ST_DEBOUNCE;
            end
         end
         ST_DEBOUNCE: begin
            if (pass_done && (frame == 16'h0000)) begin
               next_state = ST_IDLE;
            end else if (pass_done && db_done) begin
               next_state            = ST_HELD;
               next_key_scan_result  = frame;
               next_key_pressed_flag = 1'b1;
            end
         end
         ST_HELD: begin
            // keeps rescanning while held so the result tracks the keys
            if (pass_done && (frame == 16'h0000)) begin
               next_state            = ST_IDLE;
               next_key_pressed_flag = 1'b0;
            end else if (pass_done) begin
               next_key_scan_result = frame;
            end
         end
         default: begin
            if (wr_ctrl && !wr_data_in[BIT_SCAN_STATE]) begin
               next_state = ST_IDLE;
            end
         end
      endcase
      if (wr_ctrl) begin
         next_debounce_select = wr_data_in[DEB_SEL_LSB +: 3];
         if (wr_data_in[BIT_SCAN_STATE]) begin
            // halt now; the last completed result stays readable
            next_state            = ST_STOPPED;
            next_key_pressed_flag = 1'b0;
         end
      end
      if (wr_mask) begin
         next_key_mask = wr_data_in;
      end
      if (wr_dac) begin
         next_dac_level = wr_data_in[7:0];
      end
      if (soft_hit) begin
         next_state            = ST_IDLE;
         next_debounce_select  = DEB_SEL_RESET;
         next_key_mask         = MASK_RESET;
         next_key_scan_result  = RESULT_RESET;
         next_key_pressed_flag = 1'b0;
         next_dac_level        = DAC_RESET;
      end
   end

   always_ff @(posedge clock_in or negedge rst_n) begin
      if (!rst_n) begin
         state            <= ST_IDLE;
         debounce_select  <= DEB_SEL_RESET;
         key_mask         <= MASK_RESET;
         key_scan_result  <= RESULT_RESET;
         key_pressed_flag <= 1'b0;
         key_irq_n_out    <= 1'b1;
         dac_level_out    <= DAC_RESET;
         ms_div           <= '0;
         ms_count         <= 7'h00;
         row_cnt          <= 3'h0;
         row_sel          <= 2'h0;
         raw_acc          <= 16'h0000;
         row_drive_out    <= 4'h0;
      end else begin
         state            <= next_state;
         debounce_select  <= next_debounce_select;
         key_mask         <= next_key_mask;
         key_scan_result  <= next_key_scan_result;
         key_pressed_flag <= next_key_pressed_flag;
         key_irq_n_out    <= !next_key_pressed_flag;
         dac_level_out    <= next_dac_level;
         ms_div           <= next_ms_div;
         ms_count         <= next_ms_count;
         row_cnt          <= next_row_cnt;
         row_sel          <= next_row_sel;
         raw_acc          <= next_raw_acc;
         row_drive_out    <= next_row_drive;
      end
   end

   // ==========================================================
   // read path: stage one picks the word, stage two drives the port
   logic [15:0] rd_local, next_rd_local;
   logic        rd_from_store, next_rd_from_store;
   logic        rd_pend;
   logic [15:0] store_q;

   always_comb begin
      next_rd_local      = READ_RESERVED;
      next_rd_from_store = rd_en_in && rd_slot[4];
      if (is_reg(page_in, addr_in, PAGE_DATA, ADDR_KEY_RESULT)) begin
         next_rd_local = key_scan_result;
      end else if (is_reg(page_in, addr_in, PAGE_DATA, ADDR_DAC_LEVEL)) begin
         next_rd_local = {8'h00, dac_level_out};
      end else if (is_reg(page_in, addr_in, PAGE_DATA, ADDR_ZERO)) begin
         next_rd_local = READ_ZERO;
      end else if (is_reg(page_in, addr_in, PAGE_CTRL, ADDR_KEY_CTRL)) begin
         next_rd_local = {key_pressed_flag, scan_ready, debounce_select, 11'h000};
      end else if (is_reg(page_in, addr_in, PAGE_CTRL, ADDR_KEY_MASK)) begin
         next_rd_local = key_mask;
      end
   end

   always_ff @(posedge clock_in or negedge rst_n) begin
      if (!rst_n) begin
         rd_local      <= 16'h0000;
         rd_from_store <= 1'b0;
         rd_pend       <= 1'b0;
         rd_data_out   <= 16'h0000;
         rd_valid_out  <= 1'b0;
      end else begin
         rd_local      <= next_rd_local;
         rd_from_store <= next_rd_from_store;
         rd_pend       <= rd_en_in;
         rd_data_out   <= rd_from_store ? store_q : rd_local;
         rd_valid_out  <= rd_pend;
      end
   end

   kscan_conv_store #(
      .WORDS (CONV_WORDS),
      .BITS  (CONV_BITS)
   ) u_store (
      .clock_in   (clock_in),
      .rstn_in    (rst_n),
      .clear_in   (soft_hit),
      .wr_en_in   (conv_wr_in),
      .wr_idx_in  (conv_idx_in),
      .wr_data_in (conv_data_in),
      .rd_idx_in  (rd_slot[3:0]),
      .rd_q_out   (store_q)
   );

   // ==========================================================
   // checks
   property p_irq_inverse;
      @(posedge clock_in) disable iff (!rst_n) key_irq_n_out == !key_pressed_flag;
   endproperty
   a_irq_inverse: assert property (p_irq_inverse) else $error("irq pin not inverse of flag");

   property p_flag_after_debounce;
      @(posedge clock_in) disable iff (!rst_n)
         $rose(key_pressed_flag) |-> ($past(state) == ST_DEBOUNCE) && $past(db_done);
   endproperty
   a_flag_after_debounce: assert property (p_flag_after_debounce) else $error("flag rose early");

   property p_status_read;
      @(posedge clock_in) disable iff (!rst_n)
         (rd_en_in && is_reg(page_in, addr_in, PAGE_CTRL, ADDR_KEY_CTRL))
         |-> ##2 rd_valid_out && (rd_data_out[BIT_SCAN_STATE] == $past(scan_ready, 2));
   endproperty
   a_status_read: assert property (p_status_read) else $error("scan status read wrong");

   property p_stop;
      @(posedge clock_in) disable iff (!rst_n)
         (wr_ctrl && wr_data_in[BIT_SCAN_STATE] && !soft_hit)
         |=> (state == ST_STOPPED) && !key_pressed_flag ##1 (row_drive_out == 4'h0);
   endproperty
   a_stop: assert property (p_stop) else $error("scan not halted");

   property p_soft_reset;
      @(posedge clock_in) disable iff (!rst_n)
         soft_hit |=> (debounce_select == 3'h0) && (key_mask == 16'h0000)
                      && (dac_level_out == 8'h80) && (key_scan_result == 16'h0000);
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("soft reset incomplete");

   property p_bad_key;
      @(posedge clock_in) disable iff (!rst_n)
         (wr_en_in && is_reg(page_in, addr_in, PAGE_CTRL, ADDR_SOFT_RESET) && (wr_data_in[15:8] != 8'hbb))
         |=> $stable(key_mask) && $stable(debounce_select) && $stable(dac_level_out);
   endproperty
   a_bad_key: assert property (p_bad_key) else $error("bad reset key changed state");

   property p_mask_result;
      @(posedge clock_in) disable iff (!rst_n)
         $changed(key_scan_result) && !$past(soft_hit) |-> (key_scan_result & $past(key_mask)) == 16'h0000;
   endproperty
   a_mask_result: assert property (p_mask_result) else $error("masked key in result");

   property p_reserved_read;
      @(posedge clock_in) disable iff (!rst_n)
         (rd_en_in && is_reg(page_in, addr_in, PAGE_CTRL, ADDR_SOFT_RESET)) |-> ##2 (rd_data_out == 16'hffff);
   endproperty
   a_reserved_read: assert property (p_reserved_read) else $error("reset register read not ones");

   property p_release;
      @(posedge clock_in) disable iff (!rst_n)
         (state == ST_HELD) && pass_done && (frame == 16'h0000) && !wr_ctrl && !soft_hit
         |=> !key_pressed_flag ##1 key_irq_n_out;
   endproperty
   a_release: assert property (p_release) else $error("flag held after release");

   c_press:  cover property (@(posedge clock_in) disable iff (!rst_n) $rose(key_pressed_flag));
   c_multi:  cover property (@(posedge clock_in) disable iff (!rst_n)
                             key_pressed_flag && !$onehot(key_scan_result));
   c_stop:   cover property (@(posedge clock_in) disable iff (!rst_n) state == ST_STOPPED);
   c_reset:  cover property (@(posedge clock_in) disable iff (!rst_n) soft_hit);

endmodule

// >>> kscan_keypad_model.sv
// keypad matrix model: closed keys of the driven row show on the column senses
// assumes one-hot row drive; columns are pulled low while no row is driven
`timescale 1ns/10ps
module kscan_keypad_model (
   input  wire logic [3:0]  row_drive_in,  // one-hot row drive
   input  wire logic [15:0] keys_in,       // closed keys
   output logic      [3:0]  col_sense_out  // high = key closed
);
   // ==========================================
   // wired-or of driven rows; ghosting of real wires is not modelled
   always_comb begin
      col_sense_out = 4'h0;
      for (int r = 0; r < 4; r++)
         if (row_drive_in[r])
            col_sense_out |= keys_in[4*r +: 4];
   end
endmodule

// >>> test_kscan_regs.sv
// testbench for the keypad register bank: register tasks plus a keypad model
// assumes a 20-cycle ms tick so debounce times stay between 40 and 2400 cycles
`timescale 1ns/10ps
module test_kscan_regs;
   import kscan_pkg::*;
   logic        clock_in = 1'b0, rstn_in = 1'b0, rd_en_in = 1'b0, wr_en_in = 1'b0;
   logic        page_in = 1'b0, conv_wr_in = 1'b0, rd_valid_out, key_irq_n_out;
   logic [5:0]  addr_in = 6'h00;
   logic [15:0] wr_data_in = 16'h0000, rd_data_out, keys = 16'h0000;
   logic [3:0]  conv_idx_in = 4'h0, col_sense_in, row_drive_out;
   logic [11:0] conv_data_in = 12'h000;
   logic [7:0]  dac_level_out;
   int          n_fail = 0, checks_done = 0;
   // ==========================================
   // clock, design and keypad
   always #5 clock_in = ~clock_in;
   kscan_regs #(.MS_TICK_CYCLES(20)) dut (.clock_in(clock_in), .rstn_in(rstn_in), .rd_en_in(rd_en_in),
      .wr_en_in(wr_en_in), .page_in(page_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
      .col_sense_in(col_sense_in), .conv_wr_in(conv_wr_in), .conv_idx_in(conv_idx_in),
      .conv_data_in(conv_data_in), .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
      .row_drive_out(row_drive_out), .key_irq_n_out(key_irq_n_out), .dac_level_out(dac_level_out));
   kscan_keypad_model pad (.row_drive_in(row_drive_out), .keys_in(keys), .col_sense_out(col_sense_in));
   // ==========================================
   // tasks
   task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask
   task wr(input logic pg, input logic [5:0] ad, input logic [15:0] d);
      @(posedge clock_in);
      wr_en_in <= 1'b1;
      page_in <= pg;
      addr_in <= ad;
      wr_data_in <= d;
      @(posedge clock_in);
      wr_en_in <= 1'b0;
   endtask
   // read answer is launched on the edge after the sampling edge; look just after it
   task rc(input logic pg, input logic [5:0] ad, input logic [15:0] e, input string nm);
      @(posedge clock_in);
      rd_en_in <= 1'b1;
      page_in <= pg;
      addr_in <= ad;
      @(posedge clock_in);
      rd_en_in <= 1'b0;
      @(posedge clock_in);
      #1;
      chk("valid", 16'h0001, {15'h0, rd_valid_out});
      chk(nm, e, rd_data_out);
   endtask
   task wirq(input logic lvl);
      for (int i = 0; i < 600 && key_irq_n_out !== lvl; i++)
         @(posedge clock_in);
      #1;
      chk("irq_n", {15'h0, lvl}, {15'h0, key_irq_n_out});
   endtask
   task results;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // ==========================================
   // tests
   initial begin
      repeat (16) @(posedge clock_in);
      rstn_in <= 1'b1;
      repeat (3) @(posedge clock_in);
      rc(PAGE_CTRL, ADDR_KEY_CTRL, 16'h4000, "ctrl");
      rc(PAGE_CTRL, ADDR_KEY_MASK, 16'h0000, "mask");
      rc(PAGE_DATA, ADDR_KEY_RESULT, 16'h0000, "result");
      rc(PAGE_DATA, ADDR_DAC_LEVEL, 16'h0080, "dac");
      rc(PAGE_CTRL, ADDR_SOFT_RESET, 16'hffff, "srst");
      rc(PAGE_CTRL, 6'h02, 16'hffff, "reserved");
      rc(PAGE_DATA, ADDR_ZERO, 16'h0000, "zero");
      for (int s = 0; s < 8; s++) begin
         wr(PAGE_CTRL, ADDR_KEY_CTRL, {2'b00, s[2:0], 11'h000});
         rc(PAGE_CTRL, ADDR_KEY_CTRL, {2'b01, s[2:0], 11'h000}, "deb");
      end
      // 20 ms debounce leaves a wide busy window to read
      wr(PAGE_CTRL, ADDR_KEY_CTRL, 16'h1000);
      keys <= 16'h0040;
      // a first pass may miss the key, so allow two passes before looking
      repeat (100) @(posedge clock_in);
      rc(PAGE_CTRL, ADDR_KEY_CTRL, 16'h1000, "busy");
      wirq(1'b0);
      rc(PAGE_DATA, ADDR_KEY_RESULT, 16'h0040, "one");
      rc(PAGE_CTRL, ADDR_KEY_CTRL, 16'hd000, "held");
      keys <= 16'h2140;
      repeat (70) @(posedge clock_in);
      rc(PAGE_DATA, ADDR_KEY_RESULT, 16'h2140, "three");
      wr(PAGE_CTRL, ADDR_KEY_CTRL, 16'h4000);
      wirq(1'b1);
      chk("rows", 16'h0000, {12'h0, row_drive_out});
      rc(PAGE_DATA, ADDR_KEY_RESULT, 16'h2140, "kept");
      wr(PAGE_CTRL, ADDR_KEY_CTRL, 16'h0000);
      wirq(1'b0);
      keys <= 16'h0000;
      wirq(1'b1);
      wr(PAGE_CTRL, ADDR_KEY_MASK, 16'h0040);
      keys <= 16'h0040;
      repeat (300) @(posedge clock_in);
      chk("masked", 16'h0001, {15'h0, key_irq_n_out});
      keys <= 16'h0041;
      wirq(1'b0);
      rc(PAGE_DATA, ADDR_KEY_RESULT, 16'h0001, "unmasked");
      keys <= 16'h0000;
      @(posedge clock_in);
      conv_wr_in <= 1'b1;
      conv_data_in <= 12'habc;
      @(posedge clock_in);
      conv_wr_in <= 1'b0;
      rc(PAGE_DATA, 6'h00, 16'h0abc, "conv");
      wr(PAGE_DATA, ADDR_DAC_LEVEL, 16'h0033);
      wr(PAGE_CTRL, ADDR_SOFT_RESET, 16'hba00);
      rc(PAGE_CTRL, ADDR_KEY_MASK, 16'h0040, "nosrst");
      rc(PAGE_DATA, ADDR_DAC_LEVEL, 16'h0033, "nosrdac");
      chk("dac_pin", 16'h0033, {8'h00, dac_level_out});
      wr(PAGE_CTRL, ADDR_SOFT_RESET, 16'hbb55);
      rc(PAGE_CTRL, ADDR_KEY_MASK, 16'h0000, "srmask");
      rc(PAGE_DATA, ADDR_DAC_LEVEL, 16'h0080, "srdac");
      chk("srdac_pin", 16'h0080, {8'h00, dac_level_out});
      rc(PAGE_DATA, 6'h00, 16'h0000, "srconv");
      rc(PAGE_DATA, ADDR_KEY_RESULT, 16'h0000, "srres");
      results;
   end
   // hang guard, well beyond the thousand or so cycles of the tests
   initial begin
      repeat (20000) @(posedge clock_in);
      n_fail++;
      results;
   end
endmodule
